// >>> core/wwd_pkg.sv
// Purpose: shared constants for the windowed watchdog timer
// Assumes: 32-bit AXI4-Lite register access, one register per word
// Notes: register offsets are word indices; byte address is index times four
`default_nettype none
package wwd_pkg;
  // register word indices
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'hfd4;
  localparam logic [IDX_W-1:0] IDX_CODE = 12'hfd5;
  localparam logic [IDX_W-1:0] IDX_CNT = 12'hfd6;
  localparam logic [IDX_W-1:0] IDX_STAT = 12'hfd7;
  localparam logic [IDX_W-1:0] IDX_MASK = 12'hfd8;
  // control register layout
  localparam logic [7:0] CTRL_RESET = 8'ha6;
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_WIN_LSB = 3;
  localparam int CTRL_TSEL_LSB = 1;
  localparam int CTRL_ACT_BIT = 0;
  localparam logic [1:0] CTRL_FIXED = 2'h2;
  localparam logic ACT_IRQ = 1'h0;
  // control codes
  localparam logic [7:0] CLEAR_CODE = 8'h4e;
  localparam logic [7:0] DISABLE_CODE = 8'hb1;
  // counter and window
  localparam int CNT_W = 8;
  localparam int WIN_FRAC_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  // sticky status bits
  localparam int ST_W = 3;
  localparam int ST_OVF_IRQ = 0;
  localparam int ST_EARLY = 1;
  localparam int ST_OVF_RST = 2;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // prescaler: divide by 2**(base + 2*select)
  localparam int PRESCALE_BASE_DEF = 10;
  localparam int WARM_CYCLES_DEF = 16;
endpackage
`default_nettype wire

// >>> core/wwd_prescaler.sv
// Purpose: count-tick generator for the watchdog up counter
// Assumes: sel picks divide by 2**(BASE_LOG2 + 2*sel)
// Notes: clr restarts the division so a clear gives a full period
`default_nettype none
module wwd_prescaler #(
  parameter int BASE_LOG2 = 10
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic run,
  input wire logic clr,
  input wire logic [1:0] sel,
  output logic tick
);
  localparam int PW = BASE_LOG2 + 6;
  logic [PW-1:0] pre_q;
  logic [PW-1:0] mask;
  int shift;

  initial begin
    if (BASE_LOG2 < 1 || BASE_LOG2 > 24) begin
      $error("wwd_prescaler: BASE_LOG2 out of range");
    end
  end

  // low-bit mask for the selected division
  always_comb begin
    shift = BASE_LOG2 + 2 * int'(sel);
    mask = PW'((64'h1 << shift) - 64'h1);
    tick = run && ((pre_q & mask) == mask);
  end

  // free division counter, cleared while stopped
  always_ff @(posedge mclk) begin
    if (srst || clr || !run) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end
endmodule
`default_nettype wire

// >>> core/wwd_top.sv
// Purpose: windowed watchdog timer with AXI4-Lite register access
// Assumes: single clock mclk, synchronous active-high reset srst
// Notes: irq is a level; wdt_reset is a one-cycle pulse
// Functional notes
// R1: software selects interrupt request or reset as the overflow action.
// R2: watchdog starts by itself once the post-reset warm-up completes.
// R3: enable field stops at 0, runs at 1, resets to 1; writing 0 does not stop it here, it only arms the 0xb1 disable code.
// R4: 8-bit up counter; clear timing set by the clear-window field.
// R5: window 00 lets a clear code reset the counter any time.
// R6: quarter window: early clear raises interrupt, later clear resets counter.
// R7: half window: early clear raises interrupt, later clear resets counter.
// R8: three-quarter window: early clear interrupts, later clear resets counter.
// R9: code 0x4e clears; 0xb1 with enable 0 disables; others ignored.
// R10: window, time and action fields locked while enable is 1.
// R11: control register reads bit 7 as 1 and bit 6 as 0.
// R12: overflow before a valid clear asserts the selected overflow action.
//
// Implementation choice: the AXI4-Lite register port.
`default_nettype none
module wwd_top
  import wwd_pkg::*;
#(
  parameter int PRESCALE_BASE = PRESCALE_BASE_DEF,
  parameter int WARM_CYCLES = WARM_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wdt_reset
);
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
  logic arready_q, rvalid_q, irq_q, wdt_reset_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [IDX_W-1:0] widx_q, ridx;
  logic en_q, act_q, active_q, warm_done_q;
  logic [1:0] win_q, tsel_q;
  logic [CNT_W-1:0] cnt_q;
  logic [15:0] warm_cnt_q;
  logic [ST_W-1:0] st_q, mask_q, st_set;
  logic wr_go, wr_lane0, code_wr, clear_evt, early, good_clear, disable_evt;
  logic tick, ovf;
  logic rd_ctrl_q;

  initial begin
    if (WARM_CYCLES < 1 || WARM_CYCLES > 65535) begin
      $error("wwd_top: WARM_CYCLES out of range");
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;
  assign wdt_reset = wdt_reset_q;

  // write decode and control-code events
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane0 = wr_go && wstrb_q[0];
  assign code_wr = wr_lane0 && (widx_q == IDX_CODE);
  assign clear_evt = code_wr && (wdata_q[7:0] == CLEAR_CODE) && active_q;
  // R6 R7 R8: window threshold
  assign early = cnt_q < {win_q, WIN_FRAC_W'(0)};
  // R5: window 00 never early
  assign good_clear = clear_evt && !early;
  // R9: disable only with field at 0
  assign disable_evt = code_wr && (wdata_q[7:0] == DISABLE_CODE) && !en_q;
  assign ovf = active_q && tick && (cnt_q == CNT_MAX);

  // write address and data capture, either order
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
      widx_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      widx_q <= s_axi_awaddr[ADDR_W-1:2];
    end else if (bvalid_q && s_axi_bready) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge mclk) begin
    if (srst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      case (widx_q)
        IDX_CTRL, IDX_CODE, IDX_CNT, IDX_STAT, IDX_MASK: bresp_q <= RESP_OKAY;
        default: bresp_q <= RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel: data one cycle after address
  assign ridx = s_axi_araddr[ADDR_W-1:2];
  always_ff @(posedge mclk) begin
    if (srst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      rd_ctrl_q <= 1'b0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rd_ctrl_q <= (ridx == IDX_CTRL);
      case (ridx)
        // R11: fixed top bits
        IDX_CTRL: rdata_q <= {24'h0, CTRL_FIXED, en_q, win_q, tsel_q, act_q};
        IDX_CODE: rdata_q <= '0;
        IDX_CNT: rdata_q <= {24'h0, cnt_q};
        IDX_STAT: rdata_q <= {29'h0, st_q};
        IDX_MASK: rdata_q <= {29'h0, mask_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // control fields
  always_ff @(posedge mclk) begin
    if (srst) begin
      // R3: enable comes out of reset set
      en_q <= CTRL_RESET[CTRL_EN_BIT];
      win_q <= CTRL_RESET[CTRL_WIN_LSB +: 2];
      tsel_q <= CTRL_RESET[CTRL_TSEL_LSB +: 2];
      act_q <= CTRL_RESET[CTRL_ACT_BIT];
    end else if (wr_lane0 && widx_q == IDX_CTRL) begin
      en_q <= wdata_q[CTRL_EN_BIT];
      // R10: fields locked while enabled
      if (!en_q) begin
        win_q <= wdata_q[CTRL_WIN_LSB +: 2];
        tsel_q <= wdata_q[CTRL_TSEL_LSB +: 2];
        act_q <= wdata_q[CTRL_ACT_BIT];
      end
    end
  end

  // warm-up timer after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      warm_cnt_q <= '0;
      warm_done_q <= 1'b0;
    end else if (!warm_done_q) begin
      warm_cnt_q <= warm_cnt_q + 16'h1;
      warm_done_q <= (warm_cnt_q == 16'(WARM_CYCLES - 1));
    end
  end

  // run state
  always_ff @(posedge mclk) begin
    if (srst) begin
      active_q <= 1'b0;
    end else if (disable_evt) begin
      // R9: disable code stops it
      active_q <= 1'b0;
    end else if (!active_q && en_q && warm_done_q) begin
      // R2 R3: automatic start
      active_q <= 1'b1;
    end
  end

  wwd_prescaler #(
    .BASE_LOG2(PRESCALE_BASE)
  ) u_pre (
    .mclk(mclk),
    .srst(srst),
    .run(active_q),
    .clr(good_clear || disable_evt),
    .sel(tsel_q),
    .tick(tick)
  );

  // R4: 8-bit up counter
  always_ff @(posedge mclk) begin
    if (srst || good_clear || disable_evt) begin
      cnt_q <= '0;
    end else if (active_q && tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // event set terms
  always_comb begin
    st_set = '0;
    // R1 R12: overflow action select
    st_set[ST_OVF_IRQ] = ovf && (act_q == ACT_IRQ);
    st_set[ST_OVF_RST] = ovf && (act_q != ACT_IRQ);
    st_set[ST_EARLY] = clear_evt && early;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= '0;
    end else if (wr_lane0 && widx_q == IDX_STAT) begin
      st_q <= (st_q & ~wdata_q[ST_W-1:0]) | st_set;
    end else begin
      st_q <= st_q | st_set;
    end
  end

  // interrupt mask
  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_q <= '0;
    end else if (wr_lane0 && widx_q == IDX_MASK) begin
      mask_q <= wdata_q[ST_W-1:0];
    end
  end

  // outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
      wdt_reset_q <= 1'b0;
    end else begin
      irq_q <= |(st_q & mask_q);
      // R12: reset request pulse
      wdt_reset_q <= st_set[ST_OVF_RST];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_en_reset: assert property ($past(srst) |-> // R3
    en_q == CTRL_RESET[CTRL_EN_BIT] && tsel_q == CTRL_RESET[CTRL_TSEL_LSB +: 2])
    else $error("enable field not set after reset");
  a_ctrl_fixed: assert property (rvalid_q && rd_ctrl_q |-> s_axi_rdata[7:6] == CTRL_FIXED) // R11
    else $error("control bits 7:6 read wrong");
  a_auto_start: assert property ($rose(warm_done_q) && en_q |=> active_q) // R2
    else $error("watchdog did not start after warm-up");
  a_good_clear: assert property (good_clear |=> cnt_q == '0 && $stable(st_q[ST_EARLY])) // R5
    else $error("valid clear did not zero counter");
  // an early clear flags and leaves the count alone; a tick in that cycle still counts
  a_early_irq: assert property (clear_evt && early |=> // R6 R7 R8
    st_q[ST_EARLY] && cnt_q == $past(cnt_q) + CNT_W'($past(tick)))
    else $error("early clear did not raise interrupt");
  a_disable_code: assert property (disable_evt |=> !active_q ##1 cnt_q == '0) // R9
    else $error("disable code did not stop watchdog");
  a_fields_locked: assert property (en_q && !$past(srst) |=> $stable(win_q) && $stable(tsel_q) && $stable(act_q)) // R10
    else $error("locked field changed while enabled");
  a_ovf_reset: assert property (ovf && act_q |=> wdt_reset_q && cnt_q == '0) // R12
    else $error("overflow reset not asserted");
  a_ovf_irq: assert property (ovf && !act_q |=> st_q[ST_OVF_IRQ] && !wdt_reset_q) // R1
    else $error("overflow interrupt not flagged");
  a_irq_level: assert property ((st_q & mask_q) != '0 |=> irq_q)
    else $error("interrupt output not raised");

  c_early_clear: cover property (clear_evt && early);
  c_ovf_reset: cover property (ovf && act_q);
  c_disable: cover property (disable_evt ##1 !active_q);
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the windowed watchdog timer
// Assumes: short prescaler and warm-up so that overflow takes 512 cycles at time select 00
// Notes: every register access goes through the AXI4-Lite tasks
`default_nettype none
module tb
  import wwd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] awaddr = 14'h0000;
  logic [ADDR_W-1:0] araddr = 14'h0000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, irq, wdt_reset;
  wire logic [1:0] bresp;
  wire logic [1:0] rresp;
  wire logic [31:0] rdata;
  logic [31:0] rdv;
  logic [1:0] rsp;
  int bad_count = 0;
  int cmp_count = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  wwd_top #(.PRESCALE_BASE(1), .WARM_CYCLES(4)) dut_u (
    .mclk(mclk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .wdt_reset(wdt_reset)
  );

  // verdict and end of run
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // read: rready held until rvalid is sampled high
  task automatic rd(input logic [IDX_W-1:0] idx);
    @(posedge mclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // stop, zero, then load a new control value in one write
  task automatic cfg(input logic [7:0] c);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CODE, DISABLE_CODE);
    wr(IDX_CTRL, c);
  endtask

  // reset values, fixed bits, unmapped accesses
  task automatic t_reset;
    rd(IDX_CTRL);
    chk(rdv, 32'h000000a6);
    chk({31'h0, irq}, 32'h0);
    rd(12'h100);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(12'h100, 8'hff);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask

  // counter runs after warm-up without software help
  task automatic t_auto;
    cyc(400);
    rd(IDX_CNT);
    chk({31'h0, rdv[7:0] != 8'h00}, 32'h1);
  endtask

  // field lock, disable code, stop, reconfigure with enable
  task automatic t_lock;
    wr(IDX_CODE, DISABLE_CODE);
    rd(IDX_CNT);
    chk({31'h0, rdv[7:0] != 8'h00}, 32'h1);
    wr(IDX_CTRL, 8'h39);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(IDX_CTRL);
    chk(rdv, 32'h000000a6);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CTRL);
    chk(rdv, 32'h00000086);
    wr(IDX_CODE, DISABLE_CODE);
    rd(IDX_CNT);
    chk(rdv, 32'h0);
    cyc(50);
    rd(IDX_CNT);
    chk(rdv, 32'h0);
    wr(IDX_CTRL, 8'h3b);
    rd(IDX_CTRL);
    chk(rdv, 32'h000000bb);
  endtask

  // early and late clear in every window mode
  task automatic t_win;
    logic [1:0] wv;
    for (int w = 0; w < 4; w++) begin
      wv = w[1:0];
      cfg(8'h20 | {3'h0, wv, 3'h0});
      wr(IDX_MASK, 8'h07);
      wr(IDX_STAT, 8'h07);
      wr(IDX_CODE, CLEAR_CODE);
      rd(IDX_STAT);
      chk({31'h0, rdv[1]}, {31'h0, w != 0});
      chk({31'h0, irq}, {31'h0, w != 0});
      wr(IDX_STAT, 8'h07);
      cyc(w * 128 + 24);
      wr(IDX_CODE, CLEAR_CODE);
      rd(IDX_CNT);
      chk({31'h0, rdv < 32'h8}, 32'h1);
      rd(IDX_STAT);
      chk({31'h0, rdv[1]}, 32'h0);
    end
  endtask

  // overflow as interrupt, masking, then overflow as reset
  task automatic t_ovf;
    logic seen;
    cfg(8'h20);
    wr(IDX_STAT, 8'h07);
    cyc(250);
    wr(IDX_CODE, 8'h55);
    cyc(300);
    rd(IDX_STAT);
    chk(rdv, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_MASK, 8'h00);
    cyc(4);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_MASK, 8'h07);
    wr(IDX_STAT, 8'h07);
    cyc(4);
    chk({31'h0, irq}, 32'h0);
    cfg(8'h21);
    seen = 1'b0;
    repeat (700) begin
      @(posedge mclk);
      if (wdt_reset === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    rd(IDX_STAT);
    chk({29'h0, rdv[2:0]}, 32'h4);
    // time select 10: one count every 32 cycles, so about three after 100
    cfg(8'h24);
    cyc(100);
    rd(IDX_CNT);
    chk({31'h0, rdv >= 32'h2 && rdv <= 32'h4}, 32'h1);
  endtask

  // hang guard
  initial begin
    cyc(20000);
    bad_count++;
    finish_test();
  end

  // main sequence
  initial begin
    cyc(20);
    srst <= 1'b0;
    t_reset();
    t_auto();
    t_lock();
    t_win();
    t_ovf();
    finish_test();
  end
endmodule
`default_nettype wire
